// ===== cwg_pkg.sv
// constants, register map and field layout of the complementary generator
package cwg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int DB_W = 6;
    localparam int NUM_RAW = 7;

    // register byte addresses
    localparam logic [4:0] ADDR_GEN_CTRL = 5'h00;
    localparam logic [4:0] ADDR_OVR_SRC = 5'h04;
    localparam logic [4:0] ADDR_SD_CTRL = 5'h08;
    localparam logic [4:0] ADDR_DB_RISE = 5'h0c;
    localparam logic [4:0] ADDR_DB_FALL = 5'h10;

    // generator_control fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_INV_B = 4;
    localparam int BIT_INV_A = 3;
    localparam int BIT_CLK_SEL = 0;
    localparam logic [7:0] GEN_CTRL_MASK = 8'h99;
    localparam logic [7:0] GEN_CTRL_RESET = 8'h00;

    // override_and_source_select fields
    localparam int LVL_B_LSB = 6;
    localparam int LVL_A_LSB = 4;
    localparam int SRC_LSB = 0;
    localparam logic [7:0] OVR_SRC_MASK = 8'hf7;
    localparam logic [2:0] SRC_RESET = 3'h0;

    // shutdown_control fields
    localparam int BIT_EVENT = 7;
    localparam int BIT_AUTO_RESTART = 6;
    localparam int BIT_SD_COMP2 = 3;
    localparam int BIT_SD_COMP1 = 2;
    localparam int BIT_SD_PIN = 1;
    localparam logic [7:0] SD_CTRL_RESET = 8'h00;

    // override level encodings
    localparam logic [1:0] LVL_INACTIVE = 2'h0;
    localparam logic [1:0] LVL_TRISTATE = 2'h1;
    localparam logic [1:0] LVL_LOW = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;

    // input source select codes
    localparam logic [2:0] SRC_COMP1 = 3'h0;
    localparam logic [2:0] SRC_COMP2 = 3'h1;
    localparam logic [2:0] SRC_PWM1 = 3'h2;
    localparam logic [2:0] SRC_PWM2 = 3'h3;
    localparam logic [2:0] SRC_PWM3 = 3'h4;
    localparam logic [2:0] SRC_PWM4 = 3'h5;
    localparam logic [2:0] SRC_PIN = 3'h6;

    // bit positions in the raw input vector
    localparam int RAW_COMP1 = 0;
    localparam int RAW_COMP2 = 1;
    localparam int RAW_PWM1 = 2;
    localparam int RAW_PIN = 6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cwg_pkg

// ===== complementary_generator.sv
// complementary waveform generator with dead band and auto-shutdown, AXI4-Lite registers
module complementary_generator #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [cwg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [cwg_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cwg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [cwg_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SYS_OSC_TICK,
    input wire logic FAST_OSC_TICK,
    input wire logic COMP1_ASYNC_OUT,
    input wire logic COMP2_ASYNC_OUT,
    input wire logic [3:0] PWM_OUT,
    input wire logic GENERATOR_INPUT_PIN,
    output logic OUTPUT_A,
    output logic OUTPUT_A_OE,
    output logic OUTPUT_B,
    output logic OUTPUT_B_OE
);
    initial begin
        if (SYNC_STAGES < 2) begin
            $error("SYNC_STAGES must be at least 2");
        end
    end

    function automatic logic mapped(input logic [cwg_pkg::ADDR_W-1:0] a);
        mapped = (a == cwg_pkg::ADDR_GEN_CTRL) || (a == cwg_pkg::ADDR_OVR_SRC) ||
                 (a == cwg_pkg::ADDR_SD_CTRL) || (a == cwg_pkg::ADDR_DB_RISE) ||
                 (a == cwg_pkg::ADDR_DB_FALL);
    endfunction : mapped

    // registers
    logic [7:0] gen_ctrl_r;
    logic [1:0] lvl_b_r;
    logic [1:0] lvl_a_r;
    logic [2:0] src_sel_r;
    logic event_r;
    logic [6:0] sd_bits_r;
    logic [cwg_pkg::DB_W-1:0] db_rise_r;
    logic [cwg_pkg::DB_W-1:0] db_fall_r;

    // bus state
    logic aw_held_r;
    logic w_held_r;
    logic [cwg_pkg::ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [cwg_pkg::DATA_W-1:0] rdata_r;

    logic wr_fire;
    logic wr_en;
    logic [7:0] rd_byte;

    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY = !w_held_r && !bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;

    // the write commits the cycle after both halves are held
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_en = wr_fire && w_lane0_r;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= cwg_pkg::RESP_OKAY;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_r <= 1'b1;
                w_data_r <= S_AXI_WDATA[7:0];
                w_lane0_r <= S_AXI_WSTRB[0];
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= mapped(aw_addr_r) ? cwg_pkg::RESP_OKAY : cwg_pkg::RESP_SLVERR;
            end else if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read mux, unimplemented bits come back as zero
    always_comb begin
        case (S_AXI_ARADDR)
            cwg_pkg::ADDR_GEN_CTRL: rd_byte = gen_ctrl_r;
            cwg_pkg::ADDR_OVR_SRC: rd_byte = {lvl_b_r, lvl_a_r, 1'b0, src_sel_r};
            cwg_pkg::ADDR_SD_CTRL: rd_byte = {event_r, sd_bits_r};
            cwg_pkg::ADDR_DB_RISE: rd_byte = {2'h0, db_rise_r};
            cwg_pkg::ADDR_DB_FALL: rd_byte = {2'h0, db_fall_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rvalid_r <= 1'b0;
            rresp_r <= cwg_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (CE) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rvalid_r <= 1'b1;
                rdata_r <= {24'h000000, rd_byte};
                rresp_r <= mapped(S_AXI_ARADDR) ? cwg_pkg::RESP_OKAY : cwg_pkg::RESP_SLVERR;
            end else if (rvalid_r && S_AXI_RREADY) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // control bits with a defined reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            gen_ctrl_r <= cwg_pkg::GEN_CTRL_RESET;
            src_sel_r <= cwg_pkg::SRC_RESET;
            sd_bits_r <= cwg_pkg::SD_CTRL_RESET[6:0];
        end else if (CE && wr_en) begin
            case (aw_addr_r)
                cwg_pkg::ADDR_GEN_CTRL: gen_ctrl_r <= w_data_r & cwg_pkg::GEN_CTRL_MASK;
                cwg_pkg::ADDR_OVR_SRC: src_sel_r <= w_data_r[cwg_pkg::SRC_LSB +: 3];
                cwg_pkg::ADDR_SD_CTRL: sd_bits_r <= w_data_r[6:0] & 7'h4e;
                default: begin
                end
            endcase
        end
    end

    // levels and dead-band counts keep their value across reset on purpose
    always_ff @(posedge CLK) begin
        if (CE && wr_en) begin
            case (aw_addr_r)
                cwg_pkg::ADDR_OVR_SRC: begin
                    lvl_b_r <= w_data_r[cwg_pkg::LVL_B_LSB +: 2];
                    lvl_a_r <= w_data_r[cwg_pkg::LVL_A_LSB +: 2];
                end
                cwg_pkg::ADDR_DB_RISE: db_rise_r <= w_data_r[cwg_pkg::DB_W-1:0];
                cwg_pkg::ADDR_DB_FALL: db_fall_r <= w_data_r[cwg_pkg::DB_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // input synchronisers; the first stage feeds only the next stage
    logic [cwg_pkg::NUM_RAW-1:0] raw_in;
    logic [cwg_pkg::NUM_RAW-1:0] sync_r [SYNC_STAGES];
    logic [cwg_pkg::NUM_RAW-1:0] in_s;

    assign raw_in = {GENERATOR_INPUT_PIN, PWM_OUT, COMP2_ASYNC_OUT, COMP1_ASYNC_OUT};
    assign in_s = sync_r[SYNC_STAGES-1];

    genvar gs;
    generate
        for (gs = 0; gs < SYNC_STAGES; gs++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    sync_r[gs] <= '0;
                end else if (CE) begin
                    sync_r[gs] <= (gs == 0) ? raw_in : sync_r[(gs == 0) ? 0 : gs-1];
                end
            end
        end
    endgenerate

    function automatic logic shut_req(input logic [cwg_pkg::NUM_RAW-1:0] v,
                                      input logic [6:0] en);
        shut_req = (en[cwg_pkg::BIT_SD_COMP2] && v[cwg_pkg::RAW_COMP2]) ||
                   (en[cwg_pkg::BIT_SD_COMP1] && v[cwg_pkg::RAW_COMP1]) ||
                   (en[cwg_pkg::BIT_SD_PIN] && v[cwg_pkg::RAW_PIN]);
    endfunction : shut_req

    logic shut_raw;
    logic shut_s;
    assign shut_raw = shut_req(raw_in, sd_bits_r);
    assign shut_s = shut_req(in_s, sd_bits_r);

    // shutdown event flag; a hardware set wins over any clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            event_r <= 1'b0;
        end else if (CE) begin
            if (shut_s) begin
                event_r <= 1'b1;
            end else if (wr_en && aw_addr_r == cwg_pkg::ADDR_SD_CTRL) begin
                event_r <= w_data_r[cwg_pkg::BIT_EVENT];
            end else if (sd_bits_r[cwg_pkg::BIT_AUTO_RESTART]) begin
                event_r <= 1'b0;
            end
        end
    end

    // source selection and edge detection on the synchronised source
    logic src_s;
    logic src_d_r;
    logic rise;
    logic fall;
    logic tick;

    always_comb begin
        case (src_sel_r)
            cwg_pkg::SRC_COMP1: src_s = in_s[cwg_pkg::RAW_COMP1];
            cwg_pkg::SRC_COMP2: src_s = in_s[cwg_pkg::RAW_COMP2];
            cwg_pkg::SRC_PWM1, cwg_pkg::SRC_PWM2, cwg_pkg::SRC_PWM3, cwg_pkg::SRC_PWM4:
                src_s = in_s[cwg_pkg::RAW_PWM1 + int'(src_sel_r - cwg_pkg::SRC_PWM1)];
            cwg_pkg::SRC_PIN: src_s = in_s[cwg_pkg::RAW_PIN];
            default: src_s = 1'b0;
        endcase
    end

    assign rise = src_s && !src_d_r;
    assign fall = !src_s && src_d_r;
    assign tick = gen_ctrl_r[cwg_pkg::BIT_CLK_SEL] ? FAST_OSC_TICK : SYS_OSC_TICK;

    logic enabled;
    assign enabled = gen_ctrl_r[cwg_pkg::BIT_ENABLE];

    // overrides stay until the first source rising edge after the flag drops
    logic hold_r;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            src_d_r <= 1'b0;
            hold_r <= 1'b1;
        end else if (CE) begin
            src_d_r <= src_s;
            if (event_r || !enabled) begin
                hold_r <= 1'b1;
            end else if (rise) begin
                hold_r <= 1'b0;
            end
        end
    end

    // dead-band timing: each edge starts its own counter from zero
    logic a_on_r;
    logic b_on_r;
    logic rise_busy_r;
    logic fall_busy_r;
    logic [cwg_pkg::DB_W-1:0] rise_cnt_r;
    logic [cwg_pkg::DB_W-1:0] fall_cnt_r;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            a_on_r <= 1'b0;
            b_on_r <= 1'b0;
            rise_busy_r <= 1'b0;
            fall_busy_r <= 1'b0;
            rise_cnt_r <= '0;
            fall_cnt_r <= '0;
        end else if (CE) begin
            if (!enabled) begin
                a_on_r <= 1'b0;
                b_on_r <= 1'b0;
                rise_busy_r <= 1'b0;
                fall_busy_r <= 1'b0;
            end else if (rise) begin
                b_on_r <= 1'b0;
                fall_busy_r <= 1'b0;
                rise_cnt_r <= '0;
                a_on_r <= (db_rise_r == '0);
                rise_busy_r <= (db_rise_r != '0);
            end else if (fall) begin
                a_on_r <= 1'b0;
                rise_busy_r <= 1'b0;
                fall_cnt_r <= '0;
                b_on_r <= (db_fall_r == '0);
                fall_busy_r <= (db_fall_r != '0);
            end else if (tick) begin
                // an edge lands between ticks, so the wait is n-1 to n ticks
                if (rise_busy_r) begin
                    rise_cnt_r <= rise_cnt_r + 1'b1;
                    if (rise_cnt_r + 1'b1 == db_rise_r) begin
                        a_on_r <= 1'b1;
                        rise_busy_r <= 1'b0;
                    end
                end
                if (fall_busy_r) begin
                    fall_cnt_r <= fall_cnt_r + 1'b1;
                    if (fall_cnt_r + 1'b1 == db_fall_r) begin
                        b_on_r <= 1'b1;
                        fall_busy_r <= 1'b0;
                    end
                end
            end
        end
    end

    // raw fault inputs reach the pins without waiting for the synchroniser
    logic override;
    assign override = event_r || shut_raw || hold_r;

    function automatic logic [1:0] drive(input logic on, input logic inv,
                                         input logic [1:0] lvl, input logic ovr);
        // result is {output enable, level}
        if (!ovr) begin
            drive = {1'b1, on ^ inv};
        end else begin
            case (lvl)
                cwg_pkg::LVL_HIGH: drive = 2'b11;
                cwg_pkg::LVL_LOW: drive = 2'b10;
                cwg_pkg::LVL_TRISTATE: drive = 2'b00;
                default: drive = {1'b1, inv};
            endcase
        end
    endfunction : drive

    logic [1:0] drv_a;
    logic [1:0] drv_b;
    assign drv_a = drive(a_on_r, gen_ctrl_r[cwg_pkg::BIT_INV_A], lvl_a_r, override);
    assign drv_b = drive(b_on_r, gen_ctrl_r[cwg_pkg::BIT_INV_B], lvl_b_r, override);

    // a disabled module releases both pins and shows them low
    assign OUTPUT_A = enabled && drv_a[0];
    assign OUTPUT_A_OE = enabled && drv_a[1];
    assign OUTPUT_B = enabled && drv_b[0];
    assign OUTPUT_B_OE = enabled && drv_b[1];
endmodule : complementary_generator

// ===== complementary_generator_asserts.sv
// port-level checks of the complementary generator
module complementary_generator_asserts (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [cwg_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cwg_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [cwg_pkg::DATA_W-1:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic OUTPUT_A_OE,
    input wire logic OUTPUT_B_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic w_take;
    logic r_take;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // only paired address and data offers are judged; split offers are not timed here
    assign w_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    assign r_take = S_AXI_ARVALID && S_AXI_ARREADY;
    a_write_answer: assert property (w_take |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write response not two cycles after the pair was taken");
    a_read_answer: assert property (r_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read data not one cycle after the address was taken");
    a_read_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_write_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped before it was taken");
    a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped before it was taken");
    a_bad_write: assert property (w_take && S_AXI_AWADDR > 5'h10 |-> ##2 S_AXI_BRESP == cwg_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    a_bad_read: assert property (r_take && S_AXI_ARADDR > 5'h10 |=> S_AXI_RRESP == cwg_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused with zero data");
    a_good_read: assert property (r_take && S_AXI_ARADDR <= 5'h10 && S_AXI_ARADDR[1:0] == 2'h0 |=> S_AXI_RRESP == cwg_pkg::RESP_OKAY)
        else $error("mapped read not answered okay");
    a_reset_idle: assert property ($fell(RESET) |-> !OUTPUT_A_OE && !OUTPUT_B_OE && !S_AXI_BVALID)
        else $error("outputs driven right after reset");
endmodule : complementary_generator_asserts

bind complementary_generator complementary_generator_asserts i_chk (.CLK, .RESET, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .OUTPUT_A_OE, .OUTPUT_B_OE);

// ===== switch_driver_model.sv
// gate drivers of the external power switches on both outputs
module switch_driver_model (
    input wire logic a,
    input wire logic a_oe,
    input wire logic b,
    input wire logic b_oe,
    output logic a_lvl,
    output logic b_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // driver inputs carry pull-downs, so a released pin reads low, never its last value
    assign a_lvl = a_oe ? a : 1'b0;
    assign b_lvl = b_oe ? b : 1'b0;
endmodule : switch_driver_model

// ===== complementary_generator_tb.sv
// self-checking testbench of the complementary generator
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module complementary_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, RESET, fast, awv, wv, bready, arv, rready;
    logic aw_rdy, w_rdy, bv, ar_rdy, rv, oa, oa_oe, ob, ob_oe, a_lvl, b_lvl;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [1:0] bresp, rresp, resp;
    logic [6:0] raw;
    int n_mismatch, compares, r0, r1, f0, f1;
    complementary_generator i_dut (.CLK(CLK), .RESET(RESET), .CE(1'b1),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .SYS_OSC_TICK(1'b1), .FAST_OSC_TICK(fast), .COMP1_ASYNC_OUT(raw[0]),
        .COMP2_ASYNC_OUT(raw[1]), .PWM_OUT(raw[5:2]), .GENERATOR_INPUT_PIN(raw[6]),
        .OUTPUT_A(oa), .OUTPUT_A_OE(oa_oe), .OUTPUT_B(ob), .OUTPUT_B_OE(ob_oe));
    switch_driver_model i_drv (.a(oa), .a_oe(oa_oe), .b(ob), .b_oe(ob_oe), .a_lvl(a_lvl),
        .b_lvl(b_lvl));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // fast oscillator ticks every other cycle, so its dead band takes twice as long
    always @(posedge CLK) fast <= ~fast;

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    // handshakes are judged at the rising edge, with the values that stood before it
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge CLK);
            if (awv && aw_rdy) awv <= 1'b0;
            if (wv && w_rdy) wv <= 1'b0;
            if (bv && bready) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end while (!done);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        logic done;
        done = 1'b0;
        @(posedge CLK);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge CLK);
            if (arv && ar_rdy) arv <= 1'b0;
            if (rv && rready) begin
                rd_data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end while (!done);
    endtask : rd

    task automatic chk_flag(input logic e);
        rd(cwg_pkg::ADDR_SD_CTRL);
        `CHK("event flag", e, rd_data[7])
    endtask : chk_flag

    task automatic t_reset_values;
        rd(cwg_pkg::ADDR_GEN_CTRL);
        `CHK("gen ctrl", 32'h0, rd_data)
        rd(cwg_pkg::ADDR_SD_CTRL);
        `CHK("sd ctrl", 32'h0, rd_data)
        rd(cwg_pkg::ADDR_OVR_SRC);
        `CHK("source", cwg_pkg::SRC_RESET, rd_data[2:0])
        rd(5'h14);
        `CHK("bad read", cwg_pkg::RESP_SLVERR, resp)
        wr(5'h18, 8'hff);
        `CHK("bad write", cwg_pkg::RESP_SLVERR, resp)
    endtask : t_reset_values

    task automatic t_access;
        logic [4:0] ad[5] = '{5'h0c, 5'h10, 5'h04, 5'h08, 5'h00};
        logic [7:0] wv8[5] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'hff};
        logic [7:0] ex[5] = '{8'h3f, 8'h3f, 8'hf7, 8'h4e, 8'h99};
        for (int i = 0; i < 5; i++) begin
            wr(ad[i], wv8[i]);
            rd(ad[i]);
            `CHK("reg bits", {24'h0, ex[i]}, rd_data)
        end
        wr(cwg_pkg::ADDR_GEN_CTRL, 8'h00);
    endtask : t_access

    task automatic t_overrides;
        logic [1:0] lv;
        logic inv, e;
        wr(cwg_pkg::ADDR_SD_CTRL, 8'h80);
        for (int i = 0; i < 8; i++) begin
            lv = 2'(i);
            inv = i[2];
            e = lv[1] ? lv[0] : (lv[0] ? 1'b0 : inv);
            wr(cwg_pkg::ADDR_GEN_CTRL, {3'h4, inv, inv, 3'h0});
            wr(cwg_pkg::ADDR_OVR_SRC, {lv, lv, 4'h2});
            @(negedge CLK);
            `CHK("a drive", lv != cwg_pkg::LVL_TRISTATE, oa_oe)
            `CHK("b drive", lv != cwg_pkg::LVL_TRISTATE, ob_oe)
            `CHK("a level", e, a_lvl)
            `CHK("b level", e, b_lvl)
        end
    endtask : t_overrides

    task automatic t_sw_restart;
        // the access test left the longest dead band behind
        wr(cwg_pkg::ADDR_DB_RISE, 8'h00);
        wr(cwg_pkg::ADDR_DB_FALL, 8'h00);
        wr(cwg_pkg::ADDR_GEN_CTRL, 8'h80);
        wr(cwg_pkg::ADDR_OVR_SRC, 8'ha2);
        wr(cwg_pkg::ADDR_SD_CTRL, 8'h04);
        raw[2] <= 1'b1;
        repeat (8) @(posedge CLK);
        @(negedge CLK);
        `CHK("a run", 1'b1, a_lvl)
        `CHK("b run", 1'b0, b_lvl)
        @(posedge CLK);
        raw[0] <= 1'b1;
        @(negedge CLK);
        `CHK("a cut", 1'b0, a_lvl)
        repeat (3) @(posedge CLK);
        chk_flag(1'b1);
        wr(cwg_pkg::ADDR_SD_CTRL, 8'h04);
        chk_flag(1'b1);
        raw[0] <= 1'b0;
        repeat (4) @(posedge CLK);
        chk_flag(1'b1);
        wr(cwg_pkg::ADDR_SD_CTRL, 8'h04);
        chk_flag(1'b0);
        @(negedge CLK);
        `CHK("a held", 1'b0, a_lvl)
        @(posedge CLK);
        raw[2] <= 1'b0;
        repeat (8) @(posedge CLK);
        raw[2] <= 1'b1;
        repeat (8) @(posedge CLK);
        @(negedge CLK);
        `CHK("a resumed", 1'b1, a_lvl)
        @(posedge CLK);
    endtask : t_sw_restart

    task automatic t_auto_restart;
        int src_i[3] = '{6, 0, 1};
        for (int k = 0; k < 3; k++) begin
            wr(cwg_pkg::ADDR_SD_CTRL, 8'h40 | (8'h02 << k));
            raw[src_i[k]] <= 1'b1;
            repeat (4) @(posedge CLK);
            chk_flag(1'b1);
            raw[src_i[k]] <= 1'b0;
            repeat (4) @(posedge CLK);
            chk_flag(1'b0);
        end
    endtask : t_auto_restart

    task automatic t_sources;
        wr(cwg_pkg::ADDR_SD_CTRL, 8'h00);
        for (int c = 0; c < 7; c++) begin
            raw <= 7'h00;
            wr(cwg_pkg::ADDR_OVR_SRC, {5'h14, 3'(c)});
            raw <= ~(7'h01 << c);
            repeat (8) @(posedge CLK);
            @(negedge CLK);
            `CHK("other source", 1'b0, a_lvl)
            @(posedge CLK);
            raw <= 7'h7f;
            repeat (8) @(posedge CLK);
            @(negedge CLK);
            `CHK("own source", 1'b1, a_lvl)
            @(posedge CLK);
        end
    endtask : t_sources

    task automatic meas(input logic rise, output int c);
        raw[2] <= ~rise;
        repeat (150) @(posedge CLK);
        raw[2] <= rise;
        c = 0;
        do begin
            @(negedge CLK);
            c++;
        end while ((rise ? a_lvl : b_lvl) !== 1'b1 && c < 300);
        @(posedge CLK);
    endtask : meas

    task automatic t_deadband;
        wr(cwg_pkg::ADDR_OVR_SRC, 8'ha2);
        wr(cwg_pkg::ADDR_DB_RISE, 8'h00);
        wr(cwg_pkg::ADDR_DB_FALL, 8'h00);
        meas(1'b1, r0);
        meas(1'b0, f0);
        wr(cwg_pkg::ADDR_DB_RISE, 8'h3f);
        wr(cwg_pkg::ADDR_DB_FALL, 8'h05);
        meas(1'b1, r1);
        meas(1'b0, f1);
        `CHK("rise band", 1'b1, (r1 - r0) inside {63, 64})
        `CHK("fall band", 1'b1, (f1 - f0) inside {5, 6})
        wr(cwg_pkg::ADDR_GEN_CTRL, 8'h81);
        wr(cwg_pkg::ADDR_DB_RISE, 8'h03);
        meas(1'b1, r1);
        `CHK("fast band", 1'b1, (r1 - r0) inside {[5:8]})
    endtask : t_deadband

    initial begin
        RESET = 1'b1;
        {awv, wv, bready, arv, rready, fast} = 6'h0;
        awaddr = 5'h0;
        araddr = 5'h0;
        wdata = 32'h0;
        raw = 7'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        t_reset_values;
        t_access;
        t_overrides;
        t_sw_restart;
        t_auto_restart;
        t_sources;
        t_deadband;
        give_verdict;
    end

    // the whole run needs some thirteen hundred cycles
    initial begin
        #500us;
        n_mismatch++;
        give_verdict;
    end
endmodule : complementary_generator_tb
